/* File: design/btc_pkg.sv */
// Package with register map, reset values, timing constants and bus carrier for the bias timing bank.
package btc_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;

  localparam logic [ADDR_W-1:0] ADDR_GATE_DELAY = 8'h0d;
  localparam logic [ADDR_W-1:0] ADDR_OVERVOLT = 8'h0e;
  localparam logic [ADDR_W-1:0] ADDR_DIM_FREQ = 8'h0f;
  localparam logic [ADDR_W-1:0] ADDR_RESET_PULSE = 8'h10;

  localparam int NIBBLE_W = 4;
  localparam int OVP_W = 2;

  localparam logic [NIBBLE_W-1:0] RST_GATE_DELAY = 4'h2;
  localparam logic [OVP_W-1:0] RST_OVERVOLT = 2'h3;
  localparam logic [NIBBLE_W-1:0] RST_DIM_FREQ = 4'h7;
  localparam logic [NIBBLE_W-1:0] RST_RESET_PULSE = 4'h0;

  localparam logic [NIBBLE_W-1:0] GATE_MAX_CODE = 4'h7;
  localparam logic [NIBBLE_W-1:0] DIM_MAX_CODE = 4'h7;
  localparam int GATE_STEP_MS = 5;
  localparam int DIM_CODES = 8;
  localparam int DIM_BASE_KHZ = 15;
  localparam int HZ_PER_KHZ = 1000;
  localparam int MS_PER_S = 1000;
  localparam int MS_W = 6;

  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_S = 1_000_000_000;
  localparam int CLK_HZ_DEFAULT = NS_PER_S / CLK_PERIOD_NS;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } btc_bus_req_type;

  function automatic int btc_dim_period(input int clk_hz, input int code);
    return clk_hz / ((DIM_BASE_KHZ + code) * HZ_PER_KHZ);
  endfunction : btc_dim_period

endpackage : btc_pkg

/* File: design/btc_ms_timer.sv */
// Millisecond interval timer with its own fixed-period tick prescaler.
`timescale 1ns/1ps
module btc_ms_timer
  import btc_pkg::*;
#(
  parameter int TICK_CYCLES = CLK_HZ_DEFAULT / MS_PER_S,
  parameter int LOAD_W = MS_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic [LOAD_W-1:0] load_ms,
  // Status
  output logic active,
  output logic done
);

  localparam int CYC_W = $clog2(TICK_CYCLES + 1);
  localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(TICK_CYCLES - 1);
  localparam logic [LOAD_W-1:0] MS_ONE = LOAD_W'(1);

  logic [CYC_W-1:0] cyc_reg;
  logic [LOAD_W-1:0] ms_reg;
  logic active_reg;
  logic done_reg;

  wire tick_end = active_reg && (cyc_reg == CYC_LAST);
  wire last_ms = ms_reg == MS_ONE;

  // The prescaler restarts on start, so every interval is exact rather than up to one tick short.
  always_ff @(posedge clk) begin
    if (rst) begin
      cyc_reg <= '0;
      ms_reg <= '0;
      active_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (start) begin
        cyc_reg <= '0;
        ms_reg <= load_ms;
        active_reg <= load_ms != '0;
        done_reg <= load_ms == '0;
      end else if (tick_end) begin
        cyc_reg <= '0;
        ms_reg <= ms_reg - MS_ONE;
        active_reg <= !last_ms;
        done_reg <= last_ms;
      end else if (active_reg) begin
        cyc_reg <= cyc_reg + CYC_W'(1);
      end
    end
  end

  assign active = active_reg;
  assign done = done_reg;

endmodule : btc_ms_timer

/* File: design/btc_regs.sv */
// Bias timing configuration bank: four registers and the delay, pulse and dimming logic they steer.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
// Summary of operation
// - Host writes and reads back four registers.
// - Delay, dimming, pulse: bits 7-4 read zero.
// - Overvoltage register bits 7-2 read zero.
// - Gate delay code gives 5 ms steps.
// - Two-bit code selects 30 to 39 V.
// - Dimming code selects 15 to 22 kHz.
// - Reset pulse lasts code milliseconds.
module btc_regs
  import btc_pkg::*;
#(
  parameter int CLK_HZ = CLK_HZ_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire btc_bus_req_type bus,
  output logic [DATA_W-1:0] rdata,
  // Sequencing triggers from same-clock control logic
  input wire logic shaping_start,
  input wire logic reset_pulse_start,
  // Controls toward the analog and driver blocks
  output logic gate_shaping_on,
  output logic tcon_reset_pulse,
  output logic [OVP_W-1:0] backlight_led_overvoltage_threshold,
  output logic [NIBBLE_W-1:0] dimming_frequency_select,
  output logic dim_tick
);

  localparam int TICK_CYCLES = CLK_HZ / MS_PER_S;
  localparam int DIM_W = $clog2(btc_dim_period(CLK_HZ, 0) + 1);
  localparam int SEL_W = $clog2(DIM_CODES);
  localparam logic [DIM_W-1:0] DIM_ONE = DIM_W'(1);

  logic [NIBBLE_W-1:0] gate_delay_reg;
  logic [OVP_W-1:0] overvolt_reg;
  logic [NIBBLE_W-1:0] dim_freq_reg;
  logic [NIBBLE_W-1:0] pulse_len_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic gate_on_reg;
  logic pulse_reg;
  logic [DIM_W-1:0] dim_cnt_reg;
  logic dim_tick_reg;

  wire hit_gate = bus.addr == ADDR_GATE_DELAY;
  wire hit_ovp = bus.addr == ADDR_OVERVOLT;
  wire hit_dim = bus.addr == ADDR_DIM_FREQ;
  wire hit_pulse = bus.addr == ADDR_RESET_PULSE;

  wire wr_gate = bus.wr && hit_gate;
  wire wr_ovp = bus.wr && hit_ovp;
  wire wr_dim = bus.wr && hit_dim;
  wire wr_pulse = bus.wr && hit_pulse;

  wire [DATA_W-1:0] rd_gate = {{(DATA_W - NIBBLE_W){1'b0}}, gate_delay_reg};
  wire [DATA_W-1:0] rd_dim = {{(DATA_W - NIBBLE_W){1'b0}}, dim_freq_reg};
  wire [DATA_W-1:0] rd_pulse = {{(DATA_W - NIBBLE_W){1'b0}}, pulse_len_reg};
  wire [DATA_W-1:0] rd_ovp = {{(DATA_W - OVP_W){1'b0}}, overvolt_reg};

  // Unmapped addresses and idle cycles return zero.
  assign rdata_next = !bus.rd ? '0 :
                      hit_gate ? rd_gate :
                      hit_ovp ? rd_ovp :
                      hit_dim ? rd_dim :
                      hit_pulse ? rd_pulse : '0;

  always_ff @(posedge clk) begin
    if (rst) begin
      gate_delay_reg <= RST_GATE_DELAY;
      overvolt_reg <= RST_OVERVOLT;
      dim_freq_reg <= RST_DIM_FREQ;
      pulse_len_reg <= RST_RESET_PULSE;
      rdata_reg <= '0;
    end else begin
      if (wr_gate) begin
        gate_delay_reg <= bus.wdata[NIBBLE_W-1:0];
      end
      if (wr_ovp) begin
        overvolt_reg <= bus.wdata[OVP_W-1:0];
      end
      if (wr_dim) begin
        dim_freq_reg <= bus.wdata[NIBBLE_W-1:0];
      end
      if (wr_pulse) begin
        pulse_len_reg <= bus.wdata[NIBBLE_W-1:0];
      end
      rdata_reg <= rdata_next;
    end
  end

  wire [NIBBLE_W-1:0] gate_code = (gate_delay_reg > GATE_MAX_CODE) ? GATE_MAX_CODE : gate_delay_reg;
  wire [MS_W-1:0] gate_ms = MS_W'(gate_code) * MS_W'(GATE_STEP_MS);
  wire [MS_W-1:0] pulse_ms = MS_W'(pulse_len_reg);

  logic gate_done;
  logic pulse_active;

  btc_ms_timer #(
    .TICK_CYCLES(TICK_CYCLES),
    .LOAD_W(MS_W)
  ) u_gate_timer (
    .clk(clk),
    .rst(rst),
    .start(shaping_start),
    .load_ms(gate_ms),
    .active(),
    .done(gate_done)
  );

  btc_ms_timer #(
    .TICK_CYCLES(TICK_CYCLES),
    .LOAD_W(MS_W)
  ) u_pulse_timer (
    .clk(clk),
    .rst(rst),
    .start(reset_pulse_start),
    .load_ms(pulse_ms),
    .active(pulse_active),
    .done()
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      gate_on_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end else begin
      gate_on_reg <= gate_done || (gate_on_reg && !shaping_start);
      pulse_reg <= pulse_active;
    end
  end

  wire [DIM_W-1:0] dim_table [DIM_CODES];
  genvar g;
  generate
    for (g = 0; g < DIM_CODES; g++) begin : gen_dim
      assign dim_table[g] = DIM_W'(btc_dim_period(CLK_HZ, g));
    end
  endgenerate

  wire [NIBBLE_W-1:0] dim_code = (dim_freq_reg > DIM_MAX_CODE) ? DIM_MAX_CODE : dim_freq_reg;
  wire [DIM_W-1:0] dim_period = dim_table[dim_code[SEL_W-1:0]];
  // A code change mid-period must not let the counter run past the new, shorter end.
  wire dim_wrap = dim_cnt_reg >= (dim_period - DIM_ONE);

  always_ff @(posedge clk) begin
    if (rst) begin
      dim_cnt_reg <= '0;
      dim_tick_reg <= 1'b0;
    end else begin
      dim_cnt_reg <= dim_wrap ? '0 : dim_cnt_reg + DIM_ONE;
      dim_tick_reg <= dim_wrap;
    end
  end

  assign rdata = rdata_reg;
  assign gate_shaping_on = gate_on_reg;
  assign tcon_reset_pulse = pulse_reg;
  assign backlight_led_overvoltage_threshold = overvolt_reg;
  assign dimming_frequency_select = dim_freq_reg;
  assign dim_tick = dim_tick_reg;

endmodule : btc_regs

/* File: tb/btc_regs_assertions.sv */
// Checker for the bias timing register bank.
`timescale 1ns/1ps
module btc_regs_chk
  import btc_pkg::*;
#(parameter int CLK_HZ = CLK_HZ_DEFAULT) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire btc_bus_req_type bus,
  input wire logic [DATA_W-1:0] rdata,
  // Triggers and controls
  input wire logic shaping_start,
  input wire logic reset_pulse_start,
  input wire logic gate_shaping_on,
  input wire logic tcon_reset_pulse,
  input wire logic [OVP_W-1:0] backlight_led_overvoltage_threshold,
  input wire logic [NIBBLE_W-1:0] dimming_frequency_select,
  input wire logic dim_tick
);
  localparam int T = CLK_HZ / MS_PER_S;
  int since_reg;
  int hi_reg;
  int gap_reg;
  always_ff @(posedge clk) begin
    since_reg <= rst ? 0 : shaping_start ? 1 : since_reg + 1;
    hi_reg <= tcon_reset_pulse ? hi_reg + 1 : 0;
    gap_reg <= rst ? 0 : dim_tick ? 1 : gap_reg + 1;
  end
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_RD_IDLE: assert property (!$past(bus.rd) |-> rdata == 8'h00) else $error("rdata set without read");
  AST_RD_NIB: assert property ($past(bus.rd) && $past(bus.addr) != ADDR_OVERVOLT |-> rdata[7:4] == 4'h0)
    else $error("upper nibble not zero");
  AST_RD_OVP: assert property ($past(bus.rd) && $past(bus.addr) == ADDR_OVERVOLT
    |-> rdata == {6'h00, backlight_led_overvoltage_threshold}) else $error("threshold readback wrong");
  AST_OVP_OUT: assert property (bus.wr && bus.addr == ADDR_OVERVOLT ##1 !bus.wr
    |=> backlight_led_overvoltage_threshold == $past(bus.wdata[1:0], 2)) else $error("threshold output wrong");
  AST_DIM_OUT: assert property (bus.wr && bus.addr == ADDR_DIM_FREQ ##1 !bus.wr
    |=> dimming_frequency_select == $past(bus.wdata[3:0], 2)) else $error("dimming select wrong");
  // The output rises one cycle after the timer ends; the counter reads two at that sample for code zero.
  AST_GATE_DLY: assert property ($rose(gate_shaping_on) |-> (since_reg - 2) % (5 * T) == 0
    && since_reg <= 2 + 35 * T) else $error("gate delay wrong");
  AST_PULSE_LEN: assert property ($fell(tcon_reset_pulse) |-> hi_reg % T == 0 && hi_reg <= 15 * T)
    else $error("reset pulse length wrong");
  AST_DIM_GAP: assert property (dim_tick |-> gap_reg <= CLK_HZ / (DIM_BASE_KHZ * HZ_PER_KHZ))
    else $error("dimming period too long");
  cover property ($rose(gate_shaping_on));
  cover property ($fell(tcon_reset_pulse));
  cover property ($past(bus.rd) && $past(bus.addr) == ADDR_OVERVOLT);
endmodule : btc_regs_chk
bind btc_regs btc_regs_chk #(.CLK_HZ(CLK_HZ)) u_chk (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
  .shaping_start(shaping_start), .reset_pulse_start(reset_pulse_start), .gate_shaping_on(gate_shaping_on),
  .tcon_reset_pulse(tcon_reset_pulse), .backlight_led_overvoltage_threshold(backlight_led_overvoltage_threshold),
  .dimming_frequency_select(dimming_frequency_select), .dim_tick(dim_tick));

/* File: tb/testbench.sv */
// Self-checking bench for the bias timing register bank.
`timescale 1ns/1ps
module testbench;
  import btc_pkg::*;
  // A short tick keeps millisecond delays to a few thousand cycles.
  localparam int HZ = 100_000;
  localparam int T = HZ / MS_PER_S;
  logic clk;
  logic rst;
  btc_bus_req_type bus;
  logic [DATA_W-1:0] rdata;
  logic shaping_start;
  logic reset_pulse_start;
  logic gate_shaping_on;
  logic tcon_reset_pulse;
  logic [OVP_W-1:0] backlight_led_overvoltage_threshold;
  logic [NIBBLE_W-1:0] dimming_frequency_select;
  logic dim_tick;
  int n_fail = 0;
  int samples_checked = 0;
  btc_regs #(.CLK_HZ(HZ)) uut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .shaping_start(shaping_start),
    .reset_pulse_start(reset_pulse_start), .gate_shaping_on(gate_shaping_on), .tcon_reset_pulse(tcon_reset_pulse),
    .backlight_led_overvoltage_threshold(backlight_led_overvoltage_threshold), .dimming_frequency_select(dimming_frequency_select),
    .dim_tick(dim_tick));
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  // Optional write, then a read right behind it.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    @(posedge clk);
    bus <= '{a, d, w, 1'b0};
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    chk("rdata", 16'(rdata), 16'(e));
  endtask : acc
  // Counts edges until the chosen output reaches lvl, bounded.
  task automatic cnt(input int sel, input logic lvl, output int k);
    logic s;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
      s = sel == 0 ? gate_shaping_on : sel == 1 ? tcon_reset_pulse : dim_tick;
    end while (s !== lvl && k < 4000);
    if (s !== lvl) begin
      chk("timeout", 16'h0001, 16'h0000);
      conclude();
    end
  endtask : cnt
  task automatic t_reset();
    acc(0, ADDR_GATE_DELAY, 8'h00, 8'h02);
    acc(0, ADDR_OVERVOLT, 8'h00, 8'h03);
    acc(0, ADDR_DIM_FREQ, 8'h00, 8'h07);
    acc(0, ADDR_RESET_PULSE, 8'h00, 8'h00);
    chk("ovp_out", 16'(backlight_led_overvoltage_threshold), 16'h0003);
    chk("dim_sel", 16'(dimming_frequency_select), 16'h0007);
  endtask : t_reset
  // Upper bits dropped; the address past the bank is unmapped.
  task automatic t_fields();
    logic [7:0] a;
    for (int i = 0; i < 5; i++) begin
      a = 8'h0d + 8'(i);
      acc(1, a, 8'hf6, a == 8'h11 ? 8'h00 : a == ADDR_OVERVOLT ? 8'h02 : 8'h06);
      acc(1, a, 8'h59, a == 8'h11 ? 8'h00 : a == ADDR_OVERVOLT ? 8'h01 : 8'h09);
    end
    for (int c = 0; c < 4; c++) begin
      acc(1, ADDR_OVERVOLT, 8'(c), 8'(c));
      chk("ovp_out", 16'(backlight_led_overvoltage_threshold), 16'(c));
    end
  endtask : t_fields
  task automatic t_dim();
    int cs[4] = '{0, 3, 7, 12};
    int k;
    for (int i = 0; i < 4; i++) begin
      acc(1, ADDR_DIM_FREQ, 8'(cs[i]), 8'(cs[i]));
      chk("dim_sel", 16'(dimming_frequency_select), 16'(cs[i]));
      cnt(2, 1'b1, k);
      cnt(2, 1'b1, k);
      chk("dim_period", 16'(k), 16'(HZ / ((DIM_BASE_KHZ + (cs[i] > 7 ? 7 : cs[i])) * HZ_PER_KHZ)));
    end
  endtask : t_dim
  // Second start lands while the output is high, so it must drop first.
  task automatic t_gate();
    int k;
    int j;
    for (int c = 1; c < 10; c += 8) begin
      acc(1, ADDR_GATE_DELAY, 8'(c), 8'(c));
      @(posedge clk);
      shaping_start <= 1'b1;
      @(posedge clk);
      shaping_start <= 1'b0;
      cnt(0, 1'b0, k);
      cnt(0, 1'b1, j);
      chk("gate_delay", 16'(k + j), 16'(1 + GATE_STEP_MS * (c > 7 ? 7 : c) * T));
    end
  endtask : t_gate
  task automatic t_pulse();
    int k;
    for (int c = 2; c < 16; c += 13) begin
      acc(1, ADDR_RESET_PULSE, 8'(c), 8'(c));
      @(posedge clk);
      reset_pulse_start <= 1'b1;
      @(posedge clk);
      reset_pulse_start <= 1'b0;
      cnt(1, 1'b1, k);
      chk("pulse_rise", 16'(k), 16'h0001);
      cnt(1, 1'b0, k);
      chk("pulse_len", 16'(k), 16'(c * T));
    end
  endtask : t_pulse
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    bus = '0;
    shaping_start = 1'b0;
    reset_pulse_start = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_fields();
    t_dim();
    t_gate();
    t_pulse();
    conclude();
  end
endmodule : testbench
